// *** hw/osctm_pkg.sv ***
// Constants, register map and encodings for the oscillator and timer block
package osctm_pkg;

  // Clock and oscillator rates
  localparam int unsigned CLK_SYS_HZ   = 50_000_000;
  localparam int unsigned OSC_NOM_HZ   = 5_000_000;
  localparam int unsigned OSC_HALF_CYC = CLK_SYS_HZ / (2 * OSC_NOM_HZ);
  localparam int unsigned HALF_W       = $clog2(OSC_HALF_CYC + 1);
  localparam logic [HALF_W-1:0] HALF_LAST = HALF_W'(OSC_HALF_CYC - 1);

  // Divider
  localparam int unsigned DIV_W = 20;
  localparam logic [DIV_W-1:0] DIV_ZERO = 20'h00000;
  localparam logic [DIV_W-1:0] DIV_ONE  = 20'h00001;

  // Ratio select encodings
  localparam logic [1:0] RATIO_128  = 2'h0;
  localparam logic [1:0] RATIO_1024 = 2'h1;
  localparam logic [1:0] RATIO_1M   = 2'h2;

  // Counter bit that carries the divided wave, per ratio
  localparam logic [4:0] MSB_128  = 5'h06;
  localparam logic [4:0] MSB_1024 = 5'h09;
  localparam logic [4:0] MSB_1M   = 5'h13;

  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_COUNT  = 12'h008;

  // Control fields
  localparam int unsigned CTRL_EN_BIT    = 0;
  localparam int unsigned CTRL_RATIO_LO  = 1;
  localparam int unsigned CTRL_RATIO_HI  = 2;
  localparam logic        CTRL_EN_RST    = 1'b0;
  localparam logic [1:0]  CTRL_RATIO_RST = RATIO_128;

  // Status fields
  localparam int unsigned ST_OFF_BIT  = 0;
  localparam int unsigned ST_HOLD_BIT = 1;
  localparam int unsigned ST_RUN_BIT  = 2;
  localparam int unsigned ST_OSC_BIT  = 3;
  localparam int unsigned ST_DIV_BIT  = 4;

  // Divider state, one-hot
  typedef enum logic [2:0] {
    OSCTM_OFF  = 3'b001,
    OSCTM_HOLD = 3'b010,
    OSCTM_RUN  = 3'b100
  } osctm_state_e;

endpackage

// *** hw/osctm_unit.sv ***
// Housekeeping oscillator with power-of-two divider and APB control
`timescale 1ns/1ps

//
// Summary of operation
// - Oscillator disabled after reset by default
// - Raw oscillator clock at nominal 5 MHz
// - Divided output, ratio defaults to 128
// - Ratios 128, 1024, 1048576 only
// - Divider reset synchronised to oscillator clock
// - First transition delayed one oscillator cycle
// - Disable stops oscillator, holds divider reset
// - Divider reset should be oscillator-synchronous
// - Both clocks exported to routing pool
// - Unused inputs inactive, outputs may float
// - Divider reset forces divided output low
module osctm_unit
  import osctm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        osc_disable_in,
  input  wire logic        divider_reset_in,
  output logic             osc_clock_out,
  output logic             divided_clock_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [4:0] ratio_msb(input logic [1:0] sel);
    if (sel == RATIO_1024) begin
      ratio_msb = MSB_1024;
    end else if (sel == RATIO_1M) begin
      ratio_msb = MSB_1M;
    end else begin
      ratio_msb = MSB_128;
    end
  endfunction

  function automatic logic ratio_ok(input logic [1:0] sel);
    ratio_ok = (sel == RATIO_128) || (sel == RATIO_1024) || (sel == RATIO_1M);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic               en_q;
  logic [1:0]         ratio_q;
  logic [31:0]        prdata_q;
  logic               pready_q;
  logic               pslverr_q;
  logic [HALF_W-1:0]  half_q;
  logic               osc_q;
  logic               osc_rise;
  logic               osc_run;
  logic               rsync_q;
  logic [DIV_W-1:0]   div_q;
  logic               divout_q;
  osctm_state_e       state_q;
  osctm_state_e       state_d;
  logic               apb_done;
  logic               wr_ctrl;
  logic               addr_hit;
  logic [31:0]        rd_val;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered

  assign apb_done = psel && penable && pready_q;
  assign wr_ctrl  = apb_done && pwrite && (paddr == ADDR_CTRL);

  always_comb begin
    addr_hit = 1'b1;
    rd_val   = 32'h00000000;
    if (paddr == ADDR_CTRL) begin
      rd_val[CTRL_EN_BIT]                  = en_q;
      rd_val[CTRL_RATIO_HI:CTRL_RATIO_LO]  = ratio_q;
    end else if (paddr == ADDR_STATUS) begin
      rd_val[ST_OFF_BIT]  = (state_q == OSCTM_OFF);
      rd_val[ST_HOLD_BIT] = (state_q == OSCTM_HOLD);
      rd_val[ST_RUN_BIT]  = (state_q == OSCTM_RUN);
      rd_val[ST_OSC_BIT]  = osc_q;
      rd_val[ST_DIV_BIT]  = divout_q;
    end else if (paddr == ADDR_COUNT) begin
      rd_val[DIV_W-1:0] = div_q;
    end else begin
      addr_hit = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end else if (psel && penable && !pready_q) begin
      pready_q  <= 1'b1;
      pslverr_q <= !addr_hit;
      prdata_q  <= (pwrite || !addr_hit) ? 32'h00000000 : rd_val;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Control register; an unlisted ratio code keeps the old ratio
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      en_q    <= CTRL_EN_RST;
      ratio_q <= CTRL_RATIO_RST;
    end else if (wr_ctrl) begin
      en_q <= pwdata[CTRL_EN_BIT];
      if (ratio_ok(pwdata[CTRL_RATIO_HI:CTRL_RATIO_LO])) begin
        ratio_q <= pwdata[CTRL_RATIO_HI:CTRL_RATIO_LO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator model: square wave from a half-period count

  assign osc_run  = en_q && !osc_disable_in;
  assign osc_rise = osc_run && (half_q == HALF_LAST) && !osc_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      half_q <= '0;
      osc_q  <= 1'b0;
    end else if (!osc_run) begin
      // Stopped oscillator parks low so no edges leak out
      half_q <= '0;
      osc_q  <= 1'b0;
    end else if (half_q == HALF_LAST) begin
      half_q <= '0;
      osc_q  <= !osc_q;
    end else begin
      half_q <= half_q + HALF_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider reset synchroniser, clocked by oscillator rising edges

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rsync_q <= 1'b1;
    end else if (!osc_run) begin
      rsync_q <= 1'b1;
    end else if (osc_rise) begin
      // Input assumed steady around oscillator edges
      rsync_q <= divider_reset_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider state

  always_comb begin
    state_d = state_q;
    case (state_q)
      OSCTM_OFF: begin
        if (osc_run) begin
          state_d = OSCTM_HOLD;
        end
      end
      OSCTM_HOLD: begin
        if (!osc_run) begin
          state_d = OSCTM_OFF;
        end else if (osc_rise && !rsync_q) begin
          state_d = OSCTM_RUN;
        end
      end
      OSCTM_RUN: begin
        if (!osc_run) begin
          state_d = OSCTM_OFF;
        end else if (osc_rise && rsync_q) begin
          state_d = OSCTM_HOLD;
        end
      end
      default: begin
        state_d = OSCTM_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= OSCTM_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Divider counter; restarts on a control write to avoid a runt phase

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= DIV_ZERO;
    end else if (!osc_run || wr_ctrl) begin
      div_q <= DIV_ZERO;
    end else if (osc_rise) begin
      if (rsync_q) begin
        div_q <= DIV_ZERO;
      end else begin
        div_q <= div_q + DIV_ONE;
      end
    end
  end

  // Divided wave taken from the counter bit for the chosen ratio
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      divout_q <= 1'b0;
    end else if (state_q != OSCTM_RUN) begin
      divout_q <= 1'b0;
    end else begin
      divout_q <= div_q[ratio_msb(ratio_q)];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all from flops

  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign osc_clock_out     = osc_q;
  assign divided_clock_out = divout_q;

endmodule

// *** bench/osctm_props.sv ***
// Port assertions for the oscillator and timer unit
`timescale 1ns/1ps
module osctm_props (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic osc_disable_in,
  input wire logic divider_reset_in,
  input wire logic osc_clock_out,
  input wire logic divided_clock_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  sequence high_run;
    osc_clock_out[*4] ##1 !osc_clock_out;
  endsequence
  sequence low_run;
    !osc_clock_out[*4] ##1 osc_clock_out;
  endsequence
  // Disable cuts a phase short, so it suspends the phase checks
  osc_high_a: assert property (disable iff (!rst_b || osc_disable_in)
    $rose(osc_clock_out) |=> high_run) else $error("oscillator high phase wrong");
  osc_low_a: assert property (disable iff (!rst_b || osc_disable_in)
    $fell(osc_clock_out) |=> low_run) else $error("oscillator low phase wrong");
  off_default_a: assert property ($rose(rst_b) |->
    (!osc_clock_out && !divided_clock_out)[*5]) else $error("oscillator runs after reset");
  osc_stop_a: assert property (osc_disable_in |=> !osc_clock_out)
    else $error("oscillator not stopped");
  div_stop_a: assert property (osc_disable_in[*2] |=> !divided_clock_out)
    else $error("divided clock not stopped");
  div_hold_a: assert property (divider_reset_in[*8] ##1 divider_reset_in[*8]
    |=> !divided_clock_out) else $error("divided clock high in reset");
  div_high_a: assert property (disable iff (!rst_b || osc_disable_in || divider_reset_in)
    $rose(divided_clock_out) |=> divided_clock_out[*8]) else $error("divided high too short");
  div_low_a: assert property ($fell(divided_clock_out) |=> !divided_clock_out[*8])
    else $error("divided low too short");
endmodule
bind osctm_unit osctm_props chk_u (.clk_sys(clk_sys), .rst_b(rst_b),
  .osc_disable_in(osc_disable_in), .divider_reset_in(divider_reset_in),
  .osc_clock_out(osc_clock_out), .divided_clock_out(divided_clock_out));

// *** bench/osctm_user.sv ***
// Model of the user logic that drives the divider reset and disable
`timescale 1ns/1ps
module osctm_user (
  input  wire logic clk_sys,
  input  wire logic osc_clock_out,
  input  wire logic div_rst_req,
  input  wire logic dis_req,
  output logic      divider_reset_in,
  output logic      osc_disable_in
);
  logic osc_q;
  initial begin
    divider_reset_in = 1'b0;
    osc_disable_in = 1'b0;
    osc_q = 1'b0;
  end
  always @(posedge clk_sys) begin
    osc_q <= osc_clock_out;
    osc_disable_in <= dis_req;
    // Change on an oscillator fall, clear of the sampling rise
    if (osc_q && !osc_clock_out) begin
      divider_reset_in <= div_rst_req;
    end
  end
endmodule

// *** bench/osc_timer_divider_bench.sv ***
// Self-checking bench for the oscillator and timer unit
`timescale 1ns/1ps
module osc_timer_divider_bench;
  import osctm_pkg::*;
  logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, osc_o, div_o;
  logic        div_rst_req, dis_req, dri, odi, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count, compares, seed, n;
  always #10 clk_sys = ~clk_sys;
  osctm_unit dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_disable_in(odi), .divider_reset_in(dri),
    .osc_clock_out(osc_o), .divided_clock_out(div_o));
  osctm_user user_u (.clk_sys(clk_sys), .osc_clock_out(osc_o), .div_rst_req(div_rst_req),
    .dis_req(dis_req), .divider_reset_in(dri), .osc_disable_in(odi));
  ////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("mismatches %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Gap edge so the next setup never lands in this time step
    @(posedge clk_sys);
  endtask
  task automatic tog(input int lim);
    logic v;
    v = div_o;
    n = 0;
    while (div_o === v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      end_sim();
    end
  endtask
  function automatic int half_clk(input int ratio);
    return ratio / 2 * 2 * OSC_HALF_CYC;
  endfunction
  function automatic logic [2:0] ctrl_exp(input int c);
    return (c == 3) ? {RATIO_1M, 1'b1} : {c[1:0], 1'b1};
  endfunction
  ////////////////////////////////////////////////////////////
  initial begin
    {clk_sys, rst_b, psel, penable, pwrite, div_rst_req, dis_req} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    seed = 5834;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    apb(1'b0, ADDR_CTRL, 32'h00000000);
    chk("ctrl reset", 32'h00000000, rd);
    chk("osc idle", 32'h00000000, {31'h0, osc_o});
    apb(1'b0, 12'hffc, 32'h00000000);
    chk("unmapped error", 32'h00000001, {31'h0, err});
    // Code 3 is refused, so ratio 1048576 from the pass before stays
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ADDR_CTRL, ($random(seed) & 32'hfffffff8) | {29'h0, c[1:0], 1'b1});
      apb(1'b0, ADDR_CTRL, 32'h00000000);
      chk("ctrl ratio", {29'h0, ctrl_exp(c)}, {29'h0, rd[2:0]});
    end
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, ADDR_CTRL, {29'h0, c[1:0], 1'b1});
      repeat (3) tog(6000);
      chk("half period", half_clk(c ? 1024 : 128), n);
      repeat (10) @(posedge clk_sys);
    end
    div_rst_req <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk("div held low", 32'h00000000, {31'h0, div_o});
    apb(1'b0, ADDR_STATUS, 32'h00000000);
    chk("hold flag", 32'h00000001, {31'h0, rd[ST_HOLD_BIT]});
    div_rst_req <= 1'b0;
    tog(6000);
    // Release lands anywhere in an oscillator period; sync adds one more
    chk("first edge", 32'h1, {31'h0, n >= half_clk(1024) + OSC_HALF_CYC &&
      n <= half_clk(1024) + 8 * OSC_HALF_CYC});
    dis_req <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("osc stopped", 32'h00000000, {31'h0, osc_o});
    chk("div stopped", 32'h00000000, {31'h0, div_o});
    dis_req <= 1'b0;
    end_sim();
  end
endmodule
